// ---- vcc_pkg.sv ----
package vcc_pkg;

	// ********************************
	// register map
	// ********************************
	localparam logic [7:0] ADDR_GAIN_R = 8'h08;
	localparam logic [7:0] ADDR_GAIN_G = 8'h09;
	localparam logic [7:0] ADDR_GAIN_B = 8'h0A;
	localparam logic [7:0] ADDR_OFFSET_R = 8'h0B;
	localparam logic [7:0] ADDR_OFFSET_G = 8'h0C;
	localparam logic [7:0] ADDR_OFFSET_B = 8'h0D;
	localparam logic [7:0] ADDR_MODE = 8'h0E;
	localparam logic [7:0] ADDR_PLL_CLAMP = 8'h0F;
	localparam logic [7:0] ADDR_DRIVE = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h11;

	localparam int NUM_RW = 9;
	localparam int NUM_CH = 3;
	localparam logic [7:0] UNMAPPED_DATA = 8'h00;

	// ********************************
	// reset values and writable masks, index 0 is red gain
	// ********************************
	localparam logic [NUM_RW-1:0][7:0] RST_TABLE = {
		8'h34, 8'hD0, 8'hD8, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80
	};
	localparam logic [NUM_RW-1:0][7:0] MASK_TABLE = {
		8'h3C, 8'hFF, 8'hF8, 8'hFE, 8'hFE, 8'hFE, 8'hFF, 8'hFF, 8'hFF
	};
	localparam int IDX_GAIN = 0;
	localparam int IDX_OFFSET = 3;
	localparam int IDX_MODE = 6;
	localparam int IDX_PLL_CLAMP = 7;
	localparam int IDX_DRIVE = 8;

	// ********************************
	// field positions
	// ********************************
	localparam int OFFSET_LSB = 1;
	localparam int MODE_DUAL = 7;
	localparam int MODE_PARALLEL = 6;
	localparam int MODE_PORT_B_FIRST = 5;
	localparam int MODE_HS_OUT_LOW = 4;
	localparam int MODE_VS_INVERT = 3;
	localparam int PC_HS_IN_HIGH = 7;
	localparam int PC_COAST_HIGH = 6;
	localparam int PC_CLAMP_EXT = 5;
	localparam int PC_CLAMP_HIGH = 4;
	localparam int PC_PLL_BYPASS = 3;
	localparam int PC_REF_RED = 2;
	localparam int PC_REF_GREEN = 1;
	localparam int PC_REF_BLUE = 0;
	localparam int DRV_MSB = 5;
	localparam int DRV_LSB = 4;
	localparam int DRV_TRISTATE = 3;
	localparam int DRV_DET_HIGH = 2;
	localparam int ST_LSB = 1;

	typedef enum logic [1:0] {
		VCC_DRIVE_LOW = 2'h0,
		VCC_DRIVE_MED = 2'h1,
		VCC_DRIVE_HIGH = 2'h2
	} vcc_drive_t;

	// status bits 7 down to 1
	typedef struct packed {
		logic line_sync_present;
		logic green_sync_present;
		logic frame_sync_present;
		logic digital_clock_present;
		logic active_input_flag;
		logic line_sync_source_flag;
		logic frame_sync_source_flag;
	} vcc_status_t;

	typedef struct packed {
		logic [NUM_CH-1:0][7:0] gain;
		logic [NUM_CH-1:0][6:0] offset;
		logic dual_channel;
		logic parallel_out;
		logic port_b_first;
		logic pll_bypass_select;
		logic [NUM_CH-1:0] clamp_ref_mid;
		vcc_drive_t drive;
		logic output_tristate_select;
	} vcc_ctrl_t;

	// raw pins: line sync, frame sync, coast, clamp
	typedef struct packed {
		logic line_sync;
		logic frame_sync;
		logic coast;
		logic clamp;
	} vcc_pins_t;

endpackage

// ---- vcc_regs.sv ----
`timescale 1ns/10ps

// Behaviour
// - three 8-bit gain registers, default 80h; bigger gain gives less contrast
// - three 7-bit offsets in bits 7:1, default 1000000; bigger is darker
// - mode bit 7 picks single channel at 0, dual channel at 1
// - mode bit 6 picks interleaved at 0, parallel at 1
// - mode bit 5 picks port A or B for first byte after line sync
// - mode bit 4 sets line sync output active high at 0, low at 1
// - mode bit 3 inverts frame sync output when 1
// - pll/clamp bit 7 sets incoming line sync active low at 0, high at 1
// - pll/clamp bit 6 sets coast input active low at 0, high at 1
// - pll/clamp bit 5 takes clamp from line sync at 0, external pin at 1
// - pll/clamp bit 4 sets external clamp polarity, only for external source
// - pll/clamp bit 3 bypasses internal pll for external clock when 1
// - pll/clamp bits 2,1,0 pick ground or midscale clamp for red, green, blue
// - drive bits 5:4 give high for 11 or 10, medium 01, low 00
// - drive bit 3 puts data outputs in high impedance when 1
// - drive bit 2 makes sync presence output active high at 1
// - status bit 7 reads 1 while analog line sync is present
// - status bit 6 reads 1 while sync is present on green input
// - status bit 5 reads 1 while analog frame sync is present
// - status bit 4 reads 1 while digital interface clock is present
// - status bit 3 reports active interface, 1 analog, 0 digital
// - status bits 2 and 1 report line and frame sync sources in use
// - incoming line sync polarity bit applies only with its override set
// - coast polarity bit applies only with its override set
module vcc_regs (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_arst_n,
	// register port from the two-wire serial engine
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_rd,
	output logic [7:0] o_reg_rdata,
	output logic o_reg_rvalid,
	output logic o_reg_hit,
	// raw sync pins and detector levels from outside the clock domain
	input wire vcc_pkg::vcc_pins_t i_pins,
	input wire vcc_pkg::vcc_status_t i_status,
	// polarity overrides and auto-detected polarities, same clock
	input wire logic i_hs_pol_override,
	input wire logic i_hs_pol_auto_high,
	input wire logic i_coast_pol_override,
	input wire logic i_coast_pol_auto_high,
	// control to the capture core
	output vcc_pkg::vcc_ctrl_t o_ctrl,
	output logic o_data_oe,
	// processed sync outputs
	output logic o_hsync_out,
	output logic o_vsync_out,
	output logic o_coast_active,
	output logic o_clamp_active,
	output logic o_sync_presence_output
);

	// ********************************
	// register storage
	// ********************************
	logic [vcc_pkg::NUM_RW-1:0][7:0] reg_ff;
	logic [7:0] idx;
	logic in_rw;

	assign idx = i_reg_addr - vcc_pkg::ADDR_GAIN_R;
	assign in_rw = (i_reg_addr >= vcc_pkg::ADDR_GAIN_R) && (i_reg_addr <= vcc_pkg::ADDR_DRIVE);

	// masked so unused bits never store anything
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			reg_ff <= vcc_pkg::RST_TABLE;
		end else if (i_reg_wr && in_rw) begin
			reg_ff[idx[3:0]] <= i_reg_wdata & vcc_pkg::MASK_TABLE[idx[3:0]];
		end
	end

	logic [7:0] mode;
	logic [7:0] pc;
	logic [7:0] drv;
	assign mode = reg_ff[vcc_pkg::IDX_MODE];
	assign pc = reg_ff[vcc_pkg::IDX_PLL_CLAMP];
	assign drv = reg_ff[vcc_pkg::IDX_DRIVE];

	// ********************************
	// control fields
	// ********************************
	always_comb begin
		for (int c = 0; c < vcc_pkg::NUM_CH; c++) begin
			o_ctrl.gain[c] = reg_ff[vcc_pkg::IDX_GAIN + c];
			o_ctrl.offset[c] = reg_ff[vcc_pkg::IDX_OFFSET + c][7:vcc_pkg::OFFSET_LSB];
		end
		o_ctrl.dual_channel = mode[vcc_pkg::MODE_DUAL];
		o_ctrl.parallel_out = mode[vcc_pkg::MODE_PARALLEL];
		o_ctrl.port_b_first = mode[vcc_pkg::MODE_PORT_B_FIRST];
		o_ctrl.pll_bypass_select = pc[vcc_pkg::PC_PLL_BYPASS];
		o_ctrl.clamp_ref_mid = {pc[vcc_pkg::PC_REF_RED], pc[vcc_pkg::PC_REF_GREEN],
			pc[vcc_pkg::PC_REF_BLUE]};
		// 10 behaves as 11
		if (drv[vcc_pkg::DRV_MSB]) begin
			o_ctrl.drive = vcc_pkg::VCC_DRIVE_HIGH;
		end else if (drv[vcc_pkg::DRV_LSB]) begin
			o_ctrl.drive = vcc_pkg::VCC_DRIVE_MED;
		end else begin
			o_ctrl.drive = vcc_pkg::VCC_DRIVE_LOW;
		end
		o_ctrl.output_tristate_select = drv[vcc_pkg::DRV_TRISTATE];
	end

	// ********************************
	// pin synchronisers
	// ********************************
	vcc_pkg::vcc_pins_t pins_meta_ff;
	vcc_pkg::vcc_pins_t pins_ff;
	vcc_pkg::vcc_status_t st_meta_ff;
	vcc_pkg::vcc_status_t st_ff;

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pins_meta_ff <= '0;
			pins_ff <= '0;
		end else begin
			pins_meta_ff <= i_pins;
			pins_ff <= pins_meta_ff;
		end
	end

	// detector levels move slowly, so two stages without a handshake are enough
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_meta_ff <= '0;
			st_ff <= '0;
		end else begin
			st_meta_ff <= i_status;
			st_ff <= st_meta_ff;
		end
	end

	// ********************************
	// sync polarity processing
	// ********************************
	logic hs_in_high;
	logic coast_high;
	logic hs_act;
	logic coast_act;
	logic clamp_act;
	logic sync_seen;

	// without override the chip trusts its own polarity detector
	assign hs_in_high = i_hs_pol_override ? pc[vcc_pkg::PC_HS_IN_HIGH] : i_hs_pol_auto_high;
	assign coast_high = i_coast_pol_override ? pc[vcc_pkg::PC_COAST_HIGH] :
		i_coast_pol_auto_high;
	assign hs_act = pins_ff.line_sync ~^ hs_in_high;
	assign coast_act = pins_ff.coast ~^ coast_high;
	// clamp polarity only matters for the external source
	assign clamp_act = pc[vcc_pkg::PC_CLAMP_EXT] ?
		(pins_ff.clamp ~^ pc[vcc_pkg::PC_CLAMP_HIGH]) : hs_act;
	assign sync_seen = st_ff.line_sync_present | st_ff.green_sync_present |
		st_ff.digital_clock_present;

	// registered so the pins never see decode glitches
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_hsync_out <= 1'b0;
		end else begin
			o_hsync_out <= hs_act ^ mode[vcc_pkg::MODE_HS_OUT_LOW];
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_vsync_out <= 1'b0;
		end else begin
			o_vsync_out <= pins_ff.frame_sync ^ mode[vcc_pkg::MODE_VS_INVERT];
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_coast_active <= 1'b0;
		end else begin
			o_coast_active <= coast_act;
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_clamp_active <= 1'b0;
		end else begin
			o_clamp_active <= clamp_act;
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_sync_presence_output <= 1'b0;
		end else begin
			o_sync_presence_output <= sync_seen ~^ drv[vcc_pkg::DRV_DET_HIGH];
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_data_oe <= 1'b0;
		end else begin
			o_data_oe <= !drv[vcc_pkg::DRV_TRISTATE];
		end
	end

	// ********************************
	// read path
	// ********************************
	logic [7:0] rd_val;
	logic rd_hit;

	always_comb begin
		rd_val = vcc_pkg::UNMAPPED_DATA;
		rd_hit = 1'b0;
		if (in_rw) begin
			rd_val = reg_ff[idx[3:0]];
			rd_hit = 1'b1;
		end else if (i_reg_addr == vcc_pkg::ADDR_STATUS) begin
			rd_val = {st_ff, 1'b0};
			rd_hit = 1'b1;
		end
	end

	// other addresses belong to neighbouring banks, so answer zero and drop hit
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_reg_rdata <= vcc_pkg::UNMAPPED_DATA;
			o_reg_rvalid <= 1'b0;
			o_reg_hit <= 1'b0;
		end else begin
			o_reg_rvalid <= i_reg_rd;
			if (i_reg_rd) begin
				o_reg_rdata <= rd_val;
				o_reg_hit <= rd_hit;
			end
		end
	end

	// ********************************
	// assertions
	// ********************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);

	sequence wr_seq(logic [7:0] a);
		i_reg_wr && (i_reg_addr == a);
	endsequence

	sequence rd_seq(logic [7:0] a);
		i_reg_rd && (i_reg_addr == a);
	endsequence

	gain_write_a: assert property (wr_seq(vcc_pkg::ADDR_GAIN_G) |=>
		o_ctrl.gain[1] == $past(i_reg_wdata))
		else $error("green gain did not take the written value");

	offset_lsb_a: assert property (rd_seq(vcc_pkg::ADDR_OFFSET_R) |=>
		o_reg_rvalid && o_reg_hit && !o_reg_rdata[0])
		else $error("offset read returned a nonzero bit 0");

	mode_dual_a: assert property (wr_seq(vcc_pkg::ADDR_MODE) |=>
		o_ctrl.dual_channel == $past(i_reg_wdata[vcc_pkg::MODE_DUAL]))
		else $error("channel mode did not follow the write");

	hs_out_pol_a: assert property ((!hs_act && mode[vcc_pkg::MODE_HS_OUT_LOW]) |=>
		o_hsync_out)
		else $error("idle line sync output not high in active-low mode");

	vs_invert_a: assert property ((pins_ff.frame_sync && mode[vcc_pkg::MODE_VS_INVERT]) |=>
		!o_vsync_out)
		else $error("frame sync output not inverted");

	clamp_src_a: assert property ((!pc[vcc_pkg::PC_CLAMP_EXT] && hs_act) |=>
		o_clamp_active)
		else $error("clamp did not follow line sync");

	pll_bypass_a: assert property (wr_seq(vcc_pkg::ADDR_PLL_CLAMP) |=>
		o_ctrl.pll_bypass_select == $past(i_reg_wdata[vcc_pkg::PC_PLL_BYPASS]))
		else $error("pll bypass did not follow the write");

	drive_decode_a: assert property ((o_ctrl.drive == vcc_pkg::VCC_DRIVE_HIGH) ==
		drv[vcc_pkg::DRV_MSB])
		else $error("drive strength decode wrong");

	tristate_a: assert property ((wr_seq(vcc_pkg::ADDR_DRIVE) ##0
		i_reg_wdata[vcc_pkg::DRV_TRISTATE]) |=> ##1 !o_data_oe)
		else $error("data outputs still driven after tristate write");

	status_read_a: assert property (rd_seq(vcc_pkg::ADDR_STATUS) |=>
		o_reg_rdata == {$past(st_ff), 1'b0})
		else $error("status read does not match detector levels");

	hs_override_a: assert property ((!i_hs_pol_override && i_hs_pol_auto_high &&
		pins_ff.line_sync) |=> o_hsync_out == !$past(mode[vcc_pkg::MODE_HS_OUT_LOW]))
		else $error("line sync polarity bit used without override");

	// read byte seen as status fields
	vcc_pkg::vcc_status_t rd_status;
	assign rd_status = o_reg_rdata[7:vcc_pkg::ST_LSB];

	parallel_mode_a: assert property (wr_seq(vcc_pkg::ADDR_MODE) |=>
		o_ctrl.parallel_out == $past(i_reg_wdata[vcc_pkg::MODE_PARALLEL]))
		else $error("output mode did not follow the write");

	port_swap_a: assert property (wr_seq(vcc_pkg::ADDR_MODE) |=>
		o_ctrl.port_b_first == $past(i_reg_wdata[vcc_pkg::MODE_PORT_B_FIRST]))
		else $error("first port choice did not follow the write");

	offset_write_a: assert property (wr_seq(vcc_pkg::ADDR_OFFSET_B) |=>
		o_ctrl.offset[2] == $past(i_reg_wdata[7:vcc_pkg::OFFSET_LSB]))
		else $error("blue offset did not take the written value");

	hs_in_pol_a: assert property ((i_hs_pol_override && !pins_ff.line_sync &&
		!pc[vcc_pkg::PC_HS_IN_HIGH]) |=> o_hsync_out == !$past(mode[vcc_pkg::MODE_HS_OUT_LOW]))
		else $error("low line sync input not treated as active");

	coast_pol_a: assert property ((i_coast_pol_override && !pins_ff.coast &&
		!pc[vcc_pkg::PC_COAST_HIGH]) |=> o_coast_active)
		else $error("low coast input not treated as active");

	clamp_pol_a: assert property ((pc[vcc_pkg::PC_CLAMP_EXT] && !pins_ff.clamp &&
		!pc[vcc_pkg::PC_CLAMP_HIGH]) |=> o_clamp_active)
		else $error("low external clamp not treated as active");

	clamp_ref_a: assert property (wr_seq(vcc_pkg::ADDR_PLL_CLAMP) |=>
		o_ctrl.clamp_ref_mid == $past(i_reg_wdata[vcc_pkg::PC_REF_RED:vcc_pkg::PC_REF_BLUE]))
		else $error("clamp references did not follow the write");

	drive_med_a: assert property (!drv[vcc_pkg::DRV_MSB] &&
		drv[vcc_pkg::DRV_LSB] |-> o_ctrl.drive == vcc_pkg::VCC_DRIVE_MED)
		else $error("medium drive strength decode wrong");

	presence_pol_a: assert property ((!sync_seen &&
		!drv[vcc_pkg::DRV_DET_HIGH]) |=> o_sync_presence_output)
		else $error("active low presence output not high without sync");

	green_detect_a: assert property (rd_seq(vcc_pkg::ADDR_STATUS) |=>
		rd_status.green_sync_present == $past(st_ff.green_sync_present))
		else $error("green sync detect bit wrong");

	frame_detect_a: assert property (rd_seq(vcc_pkg::ADDR_STATUS) |=>
		rd_status.frame_sync_present == $past(st_ff.frame_sync_present))
		else $error("frame sync detect bit wrong");

	clock_detect_a: assert property (rd_seq(vcc_pkg::ADDR_STATUS) |=>
		rd_status.digital_clock_present == $past(st_ff.digital_clock_present))
		else $error("digital clock detect bit wrong");

	active_iface_a: assert property (rd_seq(vcc_pkg::ADDR_STATUS) |=>
		rd_status.active_input_flag == $past(st_ff.active_input_flag))
		else $error("active interface bit wrong");

	sync_source_a: assert property (rd_seq(vcc_pkg::ADDR_STATUS) |=>
		{rd_status.line_sync_source_flag, rd_status.frame_sync_source_flag} ==
		$past({st_ff.line_sync_source_flag, st_ff.frame_sync_source_flag}))
		else $error("sync source bits wrong");

	coast_override_a: assert property ((!i_coast_pol_override && !pins_ff.coast &&
		!i_coast_pol_auto_high) |=> o_coast_active)
		else $error("coast polarity bit used without override");

	mode_unused_a: assert property (rd_seq(vcc_pkg::ADDR_MODE) |=>
		(o_reg_rdata & ~vcc_pkg::MASK_TABLE[vcc_pkg::IDX_MODE]) == '0)
		else $error("unimplemented mode bits read nonzero");

	status_ro_a: assert property (wr_seq(vcc_pkg::ADDR_STATUS) |=> $stable(reg_ff))
		else $error("write to status register changed storage");

	rd_answer_a: assert property (i_reg_rd |=> o_reg_rvalid)
		else $error("read strobe not answered next cycle");

	unmapped_read_a: assert property ((i_reg_rd && !in_rw &&
		(i_reg_addr != vcc_pkg::ADDR_STATUS)) |=>
		!o_reg_hit && (o_reg_rdata == vcc_pkg::UNMAPPED_DATA))
		else $error("foreign address answered by this bank");

endmodule

// ---- vcc_host.sv ----
`timescale 1ns/10ps
// ****
// two-wire controller at the register port
// ****
module vcc_host (
	// clock
	input wire logic i_clk,
	// register port
	output logic [7:0] o_addr,
	output logic o_wr,
	output logic [7:0] o_wdata,
	output logic o_rd,
	input wire logic [7:0] i_rdata,
	input wire logic i_rvalid
);
	initial begin
		o_addr = 8'h00;
		o_wr = 1'b0;
		o_wdata = 8'h00;
		o_rd = 1'b0;
	end
	// one byte a request, released after its taking edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_wdata <= ~d;
	endtask
	// strobe is a one-cycle pulse; answer taken at the edge where valid stands
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(posedge i_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_clk);
		o_rd <= 1'b0;
		@(posedge i_clk);
		d = i_rdata;
		v = i_rvalid;
		o_addr <= ~a;
	endtask
endmodule

// ---- tb.sv ----
`timescale 1ns/10ps
module tb;
	logic i_clk = 1'b0;
	logic i_arst_n = 1'b0;
	logic [7:0] addr, wdata, rdata, d, w;
	logic wr, rd, rvalid, hit, v, oe, hs, vs, co, cl, sp, act;
	logic hso = 1'b0, hsa = 1'b0, cso = 1'b0, csa = 1'b0;
	vcc_pkg::vcc_pins_t pins = 4'h0;
	vcc_pkg::vcc_status_t st = 7'h00;
	vcc_pkg::vcc_ctrl_t ctrl;
	logic [7:0] sh [8:16];
	logic [15:0] t;
	int error_cnt = 0, n_tests = 0, cyc = 0;
	// ****
	// clock, timeout and instances
	// ****
	always #10 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			error_cnt++;
			results();
		end
	end
	vcc_host vcc_host_i (.i_clk(i_clk), .o_addr(addr), .o_wr(wr), .o_wdata(wdata),
		.o_rd(rd), .i_rdata(rdata), .i_rvalid(rvalid));
	vcc_regs vcc_regs_i (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_reg_addr(addr),
		.i_reg_wr(wr), .i_reg_wdata(wdata), .i_reg_rd(rd), .o_reg_rdata(rdata),
		.o_reg_rvalid(rvalid), .o_reg_hit(hit), .i_pins(pins), .i_status(st),
		.i_hs_pol_override(hso), .i_hs_pol_auto_high(hsa), .i_coast_pol_override(cso),
		.i_coast_pol_auto_high(csa), .o_ctrl(ctrl), .o_data_oe(oe), .o_hsync_out(hs),
		.o_vsync_out(vs), .o_coast_active(co), .o_clamp_active(cl),
		.o_sync_presence_output(sp));
	// ****
	// expectations and checks
	// ****
	// reset value in the upper byte, writable bits in the lower
	function automatic logic [15:0] rm(input logic [7:0] a);
		case (a)
			8'h08, 8'h09, 8'h0A: rm = 16'h80FF;
			8'h0B, 8'h0C, 8'h0D: rm = 16'h80FE;
			8'h0E: rm = 16'hD8F8;
			8'h0F: rm = 16'hD0FF;
			8'h10: rm = 16'h343C;
			default: rm = 16'h0000;
		endcase
	endfunction
	task chk(input string n, input logic [7:0] s, input logic [7:0] e);
		n_tests++;
		if (s !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task rdc(input logic [7:0] a, input logic [7:0] e);
		vcc_host_i.rd(a, d, v);
		chk("rvalid", v, 8'h01);
		chk("rdata", d, e);
	endtask
	task defaults;
		for (int a = 8; a <= 16; a++) begin
			t = rm(8'(a));
			sh[a] = t[15:8];
			rdc(8'(a), sh[a]);
		end
		chk("hit", hit, 8'h01);
	endtask
	task wrs(input int a, input logic [7:0] x);
		vcc_host_i.wr(8'(a), x);
		t = rm(8'(a));
		if (a < 17) sh[a] = x & t[7:0];
	endtask
	task sync_chk;
		#1;
		act = pins.line_sync ^ ~(hso ? sh[15][7] : hsa);
		chk("hsync", hs, {act ^ sh[14][4]});
		chk("vsync", vs, {pins.frame_sync ^ sh[14][3]});
		chk("coast", co, {pins.coast ^ ~(cso ? sh[15][6] : csa)});
		chk("clamp", cl, {sh[15][5] ? pins.clamp ^ ~sh[15][4] : act});
		chk("presence", sp, {(st[6] | st[5] | st[3]) ~^ sh[16][2]});
		chk("oe", oe, {~sh[16][3]});
		chk("tristate", ctrl.output_tristate_select, sh[16][3]);
		chk("mode", {ctrl.dual_channel, ctrl.parallel_out, ctrl.port_b_first},
			sh[14][7:5]);
		chk("pll", {ctrl.pll_bypass_select, ctrl.clamp_ref_mid}, sh[15][3:0]);
		chk("drive", ctrl.drive, sh[16][5] ? 8'h02 : {sh[16][4]});
		chk("gain", ctrl.gain[1], sh[9]);
		chk("gain blue", ctrl.gain[2], sh[10]);
		chk("offset red", ctrl.offset[0], sh[11][7:1]);
		chk("offset", ctrl.offset[2], sh[13][7:1]);
	endtask
	task results;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ****
	// main sequence
	// ****
	initial begin
		void'($urandom(52));
		repeat (8) @(posedge i_clk);
		i_arst_n <= 1'b1;
		defaults();
		rdc(8'h12, 8'h00);
		chk("hit", hit, 8'h00);
		$display("test defaults done");
		// all ones, all zeros, then random; 11h written too, must stay read-only
		for (int r = 0; r < 4; r++) begin
			for (int a = 8; a <= 17; a++) begin
				w = r == 0 ? 8'hFF : r == 1 ? 8'h00 : 8'($urandom);
				wrs(a, w);
			end
			for (int a = 8; a <= 16; a++)
				rdc(8'(a), sh[a]);
			rdc(8'h11, {st, 1'b0});
			sync_chk();
		end
		$display("test readback done");
		for (int i = 0; i < 40; i++) begin
			@(posedge i_clk);
			{pins, st, hso, hsa, cso, csa} <= 15'($urandom);
			for (int a = 14; a <= 16; a++)
				wrs(a, 8'($urandom));
			repeat (4) @(posedge i_clk);
			sync_chk();
			rdc(8'h11, {st, 1'b0});
		end
		$display("test sync done");
		@(posedge i_clk);
		i_arst_n <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_arst_n <= 1'b1;
		defaults();
		sync_chk();
		$display("test second reset done");
		results();
	end
endmodule
